// ---- hw/drs_defines.vh ----
// drs_defines.vh: constants for the drive run sequencer
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH
// terminal function codes
`define DRS_FUNC_W          6
`define DRS_FUNC_RUN_EN     6'h0D
`define DRS_FUNC_3WIRE      6'h0E
// safe operation selection
`define DRS_SAFE_ALWAYS     1'h0
`define DRS_SAFE_TERMINAL   1'h1
// stop method on loss of enable
`define DRS_STOP_COAST      2'h0
`define DRS_STOP_QSTOP      2'h1
`define DRS_STOP_QRESUME    2'h2
// control mode that permits dwell
`define DRS_CTRL_VF         3'h0
// defaults in tenths of seconds and hundredths of hertz
`define DRS_QSTOP_DEF       13'h0032
`define DRS_DWELL_FREQ_DEF  16'h01F4
`define DRS_DWELL_TIME_DEF  10'h000
// input qualification: 1 ms at 250 MHz (4 ns)
`define DRS_QUAL_NS         1000000
`define DRS_CLK_NS          4
`define DRS_QUAL_CYC        ((`DRS_QUAL_NS + `DRS_CLK_NS - 1) / `DRS_CLK_NS)
// 0.1 s tick at 250 MHz
`define DRS_TICK_NS         100000000
`define DRS_TICK_CYC        (`DRS_TICK_NS / `DRS_CLK_NS)
`define DRS_CNT_W           25
`endif

// ---- hw/drs_qual.v ----
// drs_qual.v: two-flop synchroniser and minimum-width filter for one terminal
module drs_qual #(
  parameter QUAL_CYC = 250000
) (
  input  wire clk,    // system clock
  input  wire rst_n,  // synchronous reset, active low
  input  wire pin,    // raw terminal level
  output reg  level   // qualified level
);
  `include "drs_defines.vh"
  reg                  sync1_reg;
  reg                  sync2_reg;
  reg [`DRS_CNT_W-1:0] cnt_reg;
  // ========================================
  // synchronise, then require a stable run
  // width qualification counter
  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 1'h0;
      sync2_reg <= 1'h0;
      cnt_reg   <= {`DRS_CNT_W{1'b0}};
      level     <= 1'h0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      // any return to the qualified level restarts the count, so short glitches never pass
      if (sync2_reg == level)
        cnt_reg <= {`DRS_CNT_W{1'b0}};
      else if (cnt_reg >= QUAL_CYC[`DRS_CNT_W-1:0] - 25'h0000001) begin
        level   <= sync2_reg;
        cnt_reg <= {`DRS_CNT_W{1'b0}};
      end else
        cnt_reg <= cnt_reg + 25'h0000001;
    end
  end
endmodule

// ---- hw/drs_top.v ----
// drs_top.v: run sequencer with three-wire latch, safe enable and dwell holds
`include "drs_defines.vh"
// Functional notes
// - three-wire function latches a momentary run press after release.
// - in three-wire mode, forward and reverse together stop the drive.
// - run-enable terminal function makes that terminal gate all run commands.
// - safe selection 0 disables gating; 1 (default) needs the enable terminal.
// - coast method blocks the output at once when enable drops.
// - quick-stop ramps down, then needs a fresh run command to restart.
// - quick-stop-resume ramps down, restarts when run present and enable on.
// - quick-stop time only for quick-stop methods; default 5 s, 0-600 s.
// - dwell holds only in plain voltage-per-frequency control mode.
// - on run, go to accel dwell frequency, hold, then normal ramp.
// - on stop, go to decel dwell frequency, hold, then ramp down.
// - dwell frequencies default 5 Hz, dwell times default 0, 0-60 s.
// - skip a dwell when its time or frequency is zero.
// - only the first acceleration after a run command dwells.
// - decel dwell only for stop ramps, not reference changes or brake control.
module drs_top #(
  parameter QUAL_CYC = `DRS_QUAL_CYC,  // terminal qualification cycles
  parameter TICK_CYC = `DRS_TICK_CYC   // cycles per 0.1 s tick
) (
  input  wire        clk,              // system clock, 250 MHz
  input  wire        rst_n,            // synchronous reset, active low
  input  wire        fwd_pin,          // forward run terminal
  input  wire        rev_pin,          // reverse run terminal
  input  wire        aux_pin,          // multi-function terminal (stop or enable)
  input  wire        enable_pin,       // dedicated enable terminal
  input  wire [5:0]  input_terminal_function, // function of aux terminal
  input  wire        gating_by_terminal,      // safe selection, 1 = gated
  input  wire [1:0]  stop_method,      // coast, quick-stop, quick-stop resume
  input  wire [12:0] qstop_time,       // quick-stop time, 0.1 s units
  input  wire [2:0]  control_mode,     // control mode, 0 = plain V/F
  input  wire [15:0] acc_dwell_freq,   // accel dwell frequency, 0.01 Hz
  input  wire [9:0]  acc_dwell_time,   // accel dwell time, 0.1 s
  input  wire [15:0] dec_dwell_freq,   // decel dwell frequency, 0.01 Hz
  input  wire [9:0]  dec_dwell_time,   // decel dwell time, 0.1 s
  input  wire [15:0] target_freq,      // speed reference, 0.01 Hz
  input  wire [15:0] output_freq,      // present ramp output, 0.01 Hz
  input  wire        brake_ctrl,       // external brake control active
  output reg         run_out,          // run request to ramp generator
  output reg         dir_rev,          // direction, 1 = reverse
  output reg         out_block,        // inverter output blocked
  output reg         use_qstop,        // ramp uses quick-stop time
  output reg  [12:0] ramp_time,        // quick-stop time, passed on every cycle
  output reg  [15:0] freq_ref,         // reference to ramp generator
  output reg         ramp_hold,        // hold ramp at present frequency
  output reg  [3:0]  dwell_state       // one-hot sequencer state
);

  // ========================================
  // operating overview
  // terminals pass two sync flops, then a width filter
  // filter length sets the shortest press that counts
  // latency from pin to run_out: 2 + QUAL_CYC + 1..2 cycles
  // three-wire: aux is the stop button, low means stop
  // run-enable function: aux becomes the enable terminal
  // otherwise the dedicated enable pin gates the run
  // config inputs are same-clock levels, read every edge
  // changing config mid-run takes effect at once
  // dwell timers count a shared 0.1 s tick
  // first tick after entering a hold may come early
  // so a hold lasts between n-1 and n tick periods
  // trade-off: one divider instead of a counter per hold
  // quick-stop ramps skip the decel dwell unless output is at or below dec_dwell_freq when enable drops
  // brake control suppresses the decel dwell only
  // outputs are all registered, one cycle after decode
  // ramp generator owns the actual frequency slope

  // ========================================
  // terminal qualification
  wire fwd_q;
  wire rev_q;
  wire aux_q;
  wire en_q;
  // one filter per terminal; all share the same width
  // forward and reverse run terminals
  drs_qual #(.QUAL_CYC(QUAL_CYC)) u_fwd (.clk(clk), .rst_n(rst_n), .pin(fwd_pin), .level(fwd_q));
  drs_qual #(.QUAL_CYC(QUAL_CYC)) u_rev (.clk(clk), .rst_n(rst_n), .pin(rev_pin), .level(rev_q));
  // multi-function terminal and dedicated enable
  drs_qual #(.QUAL_CYC(QUAL_CYC)) u_aux (.clk(clk), .rst_n(rst_n), .pin(aux_pin), .level(aux_q));
  drs_qual #(.QUAL_CYC(QUAL_CYC)) u_en  (.clk(clk), .rst_n(rst_n), .pin(enable_pin), .level(en_q));

  // ========================================
  // three-wire latch and run command
  wire three_wire = (input_terminal_function == `DRS_FUNC_3WIRE);
  wire run_en_fn  = (input_terminal_function == `DRS_FUNC_RUN_EN);
  reg  latch_reg;
  reg  latch_dir_reg;
  reg  fwd_d_reg;
  reg  rev_d_reg;
  wire fwd_rise = fwd_q & ~fwd_d_reg;
  wire rev_rise = rev_q & ~rev_d_reg;

  // enable source is the aux terminal when so assigned
  wire enable_src = run_en_fn ? aux_q : en_q;
  // selection 0 ignores the enable terminal
  // enable loss is level based, no edge needed to stop
  wire enabled    = (gating_by_terminal == `DRS_SAFE_ALWAYS) | enable_src;

  // momentary presses latch; aux low (stop button) releases
  // both directions at once stop the drive
  always @(posedge clk) begin
    if (!rst_n) begin
      latch_reg     <= 1'h0;
      latch_dir_reg <= 1'h0;
      fwd_d_reg     <= 1'h0;
      rev_d_reg     <= 1'h0;
    end else begin
      fwd_d_reg <= fwd_q;
      rev_d_reg <= rev_q;
      if (!three_wire || (fwd_q && rev_q) || !aux_q)
        latch_reg <= 1'h0;
      else if (fwd_rise) begin
        latch_reg     <= 1'h1;
        latch_dir_reg <= 1'h0;
      end else if (rev_rise) begin
        latch_reg     <= 1'h1;
        latch_dir_reg <= 1'h1;
      end
    end
  end

  // raw command: two-wire levels or the three-wire latch
  // two-wire: both directions at once cancel to no run
  wire cmd_run = three_wire ? latch_reg : (fwd_q ^ rev_q);
  wire cmd_dir = three_wire ? latch_dir_reg : rev_q;
  wire cmd_rise;
  reg  cmd_d_reg;
  assign cmd_rise = cmd_run & ~cmd_d_reg;

  // ========================================
  // safe operation: stopped by enable loss until allowed again
  reg  safe_stop_reg;
  // quick covers both ramped stop methods
  wire quick = (stop_method == `DRS_STOP_QSTOP) | (stop_method == `DRS_STOP_QRESUME);
  // stop flag set by enable loss, cleared per method
  // enable loss wins over any clear in the same cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      safe_stop_reg <= 1'h0;
      cmd_d_reg     <= 1'h0;
    end else begin
      cmd_d_reg <= cmd_run;
      if (!enabled)
        safe_stop_reg <= 1'h1;
      // quick-stop needs a new run edge after enable returns
      else if (stop_method == `DRS_STOP_QSTOP)
        safe_stop_reg <= safe_stop_reg & ~cmd_rise;
      // resume restarts at once with run present and enable on
      else
        safe_stop_reg <= 1'h0;
    end
  end
  wire run_ok = cmd_run & ~safe_stop_reg & enabled;

  // ========================================
  // 0.1 s tick divider for dwell timers
  // free running; holds are not phase aligned to it
  reg [`DRS_CNT_W-1:0] div_reg;
  wire tick = (div_reg == TICK_CYC[`DRS_CNT_W-1:0] - 25'h0000001);
  always @(posedge clk) begin
    if (!rst_n)
      div_reg <= {`DRS_CNT_W{1'b0}};
    else if (tick)
      div_reg <= {`DRS_CNT_W{1'b0}};
    else
      div_reg <= div_reg + 25'h0000001;
  end

  // ========================================
  // dwell sequencer, one-hot states
  localparam ST_STOP = 4'h1;
  localparam ST_ACC  = 4'h2;
  localparam ST_RUN  = 4'h4;
  localparam ST_DEC  = 4'h8;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [9:0] tmr_reg;
  reg [9:0] tmr_next;
  reg       first_reg;
  reg       first_next;
  reg       stopping_reg;
  reg       dec_done_reg;
  reg       dec_done_next;

  wire vf = (control_mode == `DRS_CTRL_VF);
  // dwell settings arrive as ports; defaults live outside
  // zero time or zero frequency skips a hold
  wire acc_dwell_on = vf & (acc_dwell_time != 10'h000) & (acc_dwell_freq != 16'h0000);
  wire dec_dwell_on = vf & (dec_dwell_time != 10'h000) & (dec_dwell_freq != 16'h0000) & ~brake_ctrl;
  wire at_standstill = (output_freq == 16'h0000);

  always @* begin
    state_next    = state_reg;
    tmr_next      = tmr_reg;
    first_next    = first_reg;
    dec_done_next = dec_done_reg;
    case (state_reg)
      ST_STOP: begin
        dec_done_next = 1'h0;
        if (run_ok) begin
          // only the first acceleration after a run command dwells
          first_next = 1'h0;
          tmr_next   = 10'h000;
          state_next = (acc_dwell_on && first_reg) ? ST_ACC : ST_RUN;
        end
        if (!cmd_run)
          first_next = 1'h1;
      end
      ST_ACC: begin
        // hold at dwell frequency for the dwell time, then go on
        if (!run_ok)
          state_next = ST_RUN;
        else if (output_freq >= acc_dwell_freq) begin
          if (tick)
            tmr_next = tmr_reg + 10'h001;
          if (tmr_reg >= acc_dwell_time)
            state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // only a stop ramp passing the dwell frequency holds
        if (!run_ok && dec_dwell_on && !dec_done_reg && !use_qstop &&
            output_freq <= dec_dwell_freq && !at_standstill) begin
          tmr_next   = 10'h000;
          state_next = ST_DEC;
        end else if (!run_ok && at_standstill)
          state_next = ST_STOP;
        if (!cmd_run)
          first_next = 1'h1;
      end
      ST_DEC: begin
        // hold, then continue at the normal rate
        if (tick)
          tmr_next = tmr_reg + 10'h001;
        if (tmr_reg >= dec_dwell_time || run_ok) begin
          dec_done_next = 1'h1;
          state_next    = ST_RUN;
        end
      end
      default: state_next = ST_STOP;
    endcase
  end

  // sequencer registers; a run clears the decel-done mark
  // so each new stop may dwell once more
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg    <= ST_STOP;
      tmr_reg      <= 10'h000;
      first_reg    <= 1'h1;
      dec_done_reg <= 1'h0;
      stopping_reg <= 1'h0;
    end else begin
      state_reg    <= state_next;
      tmr_reg      <= tmr_next;
      first_reg    <= first_next;
      dec_done_reg <= run_ok ? 1'h0 : dec_done_next;
      stopping_reg <= ~run_ok;
    end
  end

  // ========================================
  // registered outputs to the ramp generator
  // decoded from state_next so outputs track the state
  // dwell_state and freq_ref change on the same edge
  always @(posedge clk) begin
    if (!rst_n) begin
      run_out     <= 1'h0;
      dir_rev     <= 1'h0;
      out_block   <= 1'h1;
      use_qstop   <= 1'h0;
      ramp_time   <= `DRS_QSTOP_DEF;
      freq_ref    <= 16'h0000;
      ramp_hold   <= 1'h0;
      dwell_state <= ST_STOP;
    end else begin
      run_out     <= run_ok;
      dir_rev     <= cmd_dir;
      dwell_state <= state_next;
      // coast blocks the output the moment enable drops
      out_block   <= ((!enabled && !quick) || (state_next == ST_STOP && !run_ok));
      // quick-stop time only under the quick-stop methods
      use_qstop   <= safe_stop_reg & quick & ~run_ok;
      ramp_time   <= qstop_time;
      // hold only once the dwell frequency is reached
      ramp_hold   <= ((state_next == ST_ACC) && (output_freq >= acc_dwell_freq)) ||
                     (state_next == ST_DEC);
      case (state_next)
        ST_ACC:  freq_ref <= acc_dwell_freq;
        ST_DEC:  freq_ref <= dec_dwell_freq;
        ST_RUN:  freq_ref <= run_ok ? target_freq : 16'h0000;
        default: freq_ref <= 16'h0000;
      endcase
    end
  end
endmodule

// ---- tb/drs_sva.sv ----
// drs_sva.sv: port checker for the run sequencer
module drs_sva #(
  parameter int QUAL_CYC = 4
) (
  input logic        clk, rst_n, fwd_pin, rev_pin, aux_pin, enable_pin, // clock, reset, terminals
  input logic        gating_by_terminal, run_out, out_block, use_qstop, ramp_hold, // levels
  input logic [5:0]  input_terminal_function, // aux function
  input logic [1:0]  stop_method,             // stop method
  input logic [2:0]  control_mode,            // control mode
  input logic [12:0] qstop_time, ramp_time,   // quick-stop times
  input logic [15:0] acc_dwell_freq, freq_ref, // frequencies
  input logic [9:0]  acc_dwell_time,          // accel dwell time
  input logic [3:0]  dwell_state              // one-hot state
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = QUAL_CYC + 6;
  logic [7:0] off_cnt_reg, both_cnt_reg;
  logic       en_src;
  // ====================
  // helpers
  // raw counts stand in for qualified levels, so limits carry slack
  assign en_src = (input_terminal_function == 6'h0D) ? aux_pin : enable_pin;
  always @(posedge clk) begin
    if (!rst_n) begin
      off_cnt_reg  <= 8'h00;
      both_cnt_reg <= 8'h00;
    end else begin
      off_cnt_reg  <= en_src ? 8'h00 : off_cnt_reg + {7'h00, off_cnt_reg != 8'hFF};
      both_cnt_reg <= (fwd_pin && rev_pin) ? both_cnt_reg + {7'h00, both_cnt_reg != 8'hFF} : 8'h00;
    end
  end
  // ====================
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_state_one_hot: assert property ($onehot(dwell_state)) else $error("state not one-hot");
  a_coast_blocks: assert property (gating_by_terminal && stop_method == 2'h0 && off_cnt_reg == LIM
    |-> out_block && !run_out) else $error("coast did not block");
  a_qstop_engaged: assert property (gating_by_terminal && stop_method != 2'h0 && run_out && !en_src
    |-> ##[1:LIM] use_qstop) else $error("quick-stop not engaged");
  a_qstop_time: assert property (use_qstop && $stable(qstop_time) |-> ramp_time == qstop_time)
    else $error("quick-stop time wrong");
  a_mode_no_dwell: assert property (control_mode != 3'h0 && $past(control_mode) != 3'h0
    && dwell_state == 4'h1 |=> dwell_state != 4'h2) else $error("dwell outside plain mode");
  a_zero_skip: assert property ((dwell_state == 4'h1 && (acc_dwell_time == 10'h000
    || acc_dwell_freq == 16'h0000)) ##1 dwell_state != 4'h1 |-> dwell_state == 4'h4)
    else $error("zero dwell not skipped");
  a_acc_ref: assert property (dwell_state == 4'h2 && $past(dwell_state) == 4'h2
    && $stable(acc_dwell_freq) |-> freq_ref == acc_dwell_freq) else $error("dwell reference wrong");
  a_idle_no_hold: assert property (dwell_state == 4'h1 && $past(dwell_state) == 4'h1 |-> !ramp_hold)
    else $error("hold while stopped");
  a_both_stop: assert property (input_terminal_function == 6'h0E && both_cnt_reg == LIM |-> !run_out)
    else $error("both buttons kept running");
  c_acc_dwell: cover property (dwell_state == 4'h2 && ramp_hold);
  c_dec_dwell: cover property (dwell_state == 4'h8);
  c_qstop: cover property (use_qstop);
endmodule

// ---- tb/drs_buttons.sv ----
// drs_buttons.sv: push buttons and enable switch on the terminals
module drs_buttons #(
  parameter int QUAL_CYC = 4
) (
  input  wire logic clk,            // system clock
  output logic      fwd_pin = 1'b0, // forward button
  output logic      rev_pin = 1'b0, // reverse button
  output logic      aux_pin = 1'b1, // stop button or enable
  output logic      enable_pin = 1'b1 // enable switch
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // level changes land at the falling edge, away from sampling
  task automatic drive(input logic f, r, a, e);
    @(negedge clk);
    {fwd_pin, rev_pin, aux_pin, enable_pin} = {f, r, a, e};
  endtask
  task automatic press(input logic f, r, input int n);
    drive(f, r, aux_pin, enable_pin);
    repeat (n) @(negedge clk);
    drive(1'b0, 1'b0, aux_pin, enable_pin);
  endtask
endmodule

// ---- tb/testbench.sv ----
// testbench.sv: self-checking bench for the run sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QC = 4;
  logic        clk = 0, rst_n = 0, gating_by_terminal = 0, brake_ctrl = 0;
  logic        fwd_pin, rev_pin, aux_pin, enable_pin, run_out, dir_rev, out_block, use_qstop, ramp_hold;
  logic [5:0]  input_terminal_function = 6'h0E;
  logic [1:0]  stop_method = 2'h0;
  logic [12:0] qstop_time = 13'h1770, ramp_time;
  logic [2:0]  control_mode = 3'h0;
  logic [15:0] acc_dwell_freq = 16'h01F4, dec_dwell_freq = 16'h01F4, target_freq = 16'h1388;
  logic [15:0] output_freq = 16'h0000, freq_ref;
  logic [9:0]  acc_dwell_time = 10'h000, dec_dwell_time = 10'h000;
  logic [3:0]  dwell_state;
  int          fails = 0, n_compared = 0;
  // ====================
  // clock and instances
  always #2 clk = ~clk;
  drs_buttons #(.QUAL_CYC(QC)) u_btn (.clk, .fwd_pin, .rev_pin, .aux_pin, .enable_pin);
  drs_top #(.QUAL_CYC(QC), .TICK_CYC(8)) uut (.*);
  // ====================
  // checking tasks
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait; a miss counts and ends the run
  task automatic wait_state(input logic [3:0] s);
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (dwell_state === s) return;
    end
    chk(dwell_state, s);
    wrap_up();
  endtask
  // qualification plus latch latency, with margin
  task automatic settle;
    repeat (QC + 8) @(negedge clk);
  endtask
  // ====================
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    chk(out_block, 1'b1);
    chk(ramp_time, 16'h0032);
    chk(dwell_state, 4'h1);
    rst_n = 1;
    settle;
    u_btn.press(1, 0, QC - 2);
    settle;
    chk(run_out, 1'b0);
    u_btn.press(1, 0, QC + 4);
    settle;
    chk(run_out, 1'b1);
    chk(dir_rev, 1'b0);
    chk(dwell_state, 4'h4);
    u_btn.press(1, 1, QC + 4);
    settle;
    chk(run_out, 1'b0);
    wait_state(4'h1);
    // two-wire run with both dwells
    input_terminal_function = 6'h00;
    acc_dwell_time = 10'h003;
    dec_dwell_time = 10'h002;
    u_btn.drive(1, 0, 1, 1);
    wait_state(4'h2);
    chk(freq_ref, acc_dwell_freq);
    output_freq = 16'h01F4;
    settle;
    chk(ramp_hold, 1'b1);
    wait_state(4'h4);
    chk(freq_ref, target_freq);
    output_freq = 16'h1388;
    u_btn.drive(0, 0, 1, 1);
    settle;
    chk(freq_ref, 16'h0000);
    output_freq = 16'h01F4;
    wait_state(4'h8);
    output_freq = 16'h0000;
    wait_state(4'h1);
    // other control mode: a dwell would stall at zero output
    control_mode = 3'h1;
    u_btn.drive(1, 0, 1, 1);
    wait_state(4'h4);
    u_btn.drive(0, 0, 1, 1);
    wait_state(4'h1);
    control_mode = 3'h0;
    acc_dwell_time = 10'h000;
    // gated run, coast on enable loss
    gating_by_terminal = 1;
    u_btn.drive(1, 0, 1, 1);
    wait_state(4'h4);
    u_btn.drive(1, 0, 1, 0);
    settle;
    chk(out_block, 1'b1);
    chk(run_out, 1'b0);
    // quick-stop then enable alone must not restart
    stop_method = 2'h1;
    u_btn.drive(0, 0, 1, 1);
    settle;
    u_btn.drive(1, 0, 1, 1);
    wait_state(4'h4);
    chk(out_block, 1'b0);
    u_btn.drive(1, 0, 1, 0);
    settle;
    chk(use_qstop, 1'b1);
    chk(ramp_time, qstop_time);
    u_btn.drive(1, 0, 1, 1);
    settle;
    chk(run_out, 1'b0);
    // quick-stop with resume
    stop_method = 2'h2;
    u_btn.drive(0, 0, 1, 1);
    settle;
    u_btn.drive(1, 0, 1, 1);
    wait_state(4'h4);
    u_btn.drive(1, 0, 1, 0);
    settle;
    chk(use_qstop, 1'b1);
    u_btn.drive(1, 0, 1, 1);
    settle;
    chk(run_out, 1'b1);
    // aux terminal assigned as run enable
    input_terminal_function = 6'h0D;
    u_btn.drive(1, 0, 0, 1);
    settle;
    chk(run_out, 1'b0);
    chk(use_qstop, 1'b1);
    u_btn.drive(1, 0, 1, 1);
    settle;
    chk(run_out, 1'b1);
    wrap_up();
  end
endmodule
bind drs_top drs_sva #(.QUAL_CYC(QUAL_CYC)) u_sva (.*);
